// ---- spf_rx_port.sv ----
// Fabric-side port of the standard PCS: word placement, FIFOs, byte ordering
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module spf_rx_port #(
    parameter int DEPTH = spf_pkg::SPF_FIFO_DEPTH,
    parameter int TX_DIV = spf_pkg::SPF_TX_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Receive words from the PCS
    input wire logic pcsRxValid,
    input wire logic [9:0] pcsRxData,
    input wire logic pcsRxCtrl,
    input wire logic pcsRxCodeErr,
    input wire logic pcsRxSync,
    input wire logic pcsRxDispErr,
    input wire logic pcsRxPattern,
    input wire logic pcsRxRunDisp,
    // Receive fabric side
    input wire logic rxCoreClkEn,
    output logic [spf_pkg::SPF_BUS_W-1:0] rxParallelData,
    output logic rxDataValid,
    output logic rxStdClkOut,
    output logic rxPcFifoFull,
    output logic rxPcFifoEmpty,
    input wire logic rxByteOrderReq,
    output logic rxByteOrderDone,
    // Transmit fabric side
    input wire logic txCoreClkEn,
    input wire logic txWrite,
    input wire logic [spf_pkg::SPF_BUS_W-1:0] txParallelData,
    output logic txStdClkOut,
    output logic txPcFifoFull,
    output logic txPcFifoEmpty,
    // Transmit words to the PCS
    output logic [spf_pkg::SPF_BUS_W-1:0] txPcsData,
    output logic txPcsValid
);
    import spf_pkg::*;

    localparam int DW = $clog2(TX_DIV);

    generate
        if (TX_DIV < 2) begin : gCheck
            $error("spf_rx_port divider must be at least two");
        end
    endgenerate

    // Registers
    logic [SPF_CTRL_W-1:0] ctrl_q;
    logic [31:0] ordCount_q;
    logic overrun_q;
    logic ordSeen_q;
    logic ack_q;
    logic regWr;
    logic regRd;
    logic [31:0] rdData_d;

    // Configuration decode
    logic cfgDouble;
    logic cfgDeser;
    logic cfgManual;
    logic cfgEnc;
    spf_pma_t cfgPma;
    logic byteRevActive;

    // Receive path
    logic [SPF_SLOT_W-1:0] rxWord;
    logic [SPF_SLOT_W-1:0] rxWordOrd;
    logic [SPF_BUS_W-1:0] beat_q;
    logic [SPF_BUS_W-1:0] beat_d;
    logic [1:0] idx_q;
    logic [1:0] idxUse;
    logic beatDone;
    logic ordArmed_q;
    logic ordNow;
    logic rxPopPend_q;

    // Transmit path
    logic [DW-1:0] div_q;
    logic txTick;
    logic txPopPend_q;

    spf_fifo_if #(.W(SPF_BUS_W)) rxFifo ();
    spf_fifo_if #(.W(SPF_BUS_W)) txFifo ();

    assign cfgDouble = ctrl_q[SPF_CTRL_DOUBLE];
    assign cfgDeser = ctrl_q[SPF_CTRL_DESER];
    assign cfgManual = ctrl_q[SPF_CTRL_MANUAL];
    assign cfgEnc = ctrl_q[SPF_CTRL_ENC];
    assign cfgPma = spf_pma_t'(ctrl_q[SPF_CTRL_PMA_LO +: 2]);
    assign byteRevActive = ctrl_q[SPF_CTRL_BYTEREV]
        && (cfgPma == SPF_PMA_16 || cfgPma == SPF_PMA_20);

    // Avalon slave: one wait cycle, answer at the second edge
    // Writes land at the completing edge; read data is ready by then
    assign avsWaitRequest = (avsRead || avsWrite) && !ack_q;
    assign regWr = avsWrite && ack_q;
    assign regRd = avsRead && !ack_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avsRead || avsWrite) && !ack_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= SPF_CTRL_RESET;
        end else if (regWr && avsAddress == SPF_REG_CTRL && avsByteEnable[0]) begin
            ctrl_q <= avsWriteData[SPF_CTRL_W-1:0];
        end
    end

    always_comb begin
        rdData_d = '0;
        if (avsAddress == SPF_REG_CTRL) begin
            rdData_d[SPF_CTRL_W-1:0] = ctrl_q;
        end else if (avsAddress == SPF_REG_STATUS) begin
            rdData_d[SPF_ST_RXFULL] = rxFifo.full;
            rdData_d[SPF_ST_RXEMPTY] = rxFifo.empty;
            rdData_d[SPF_ST_TXFULL] = txFifo.full;
            rdData_d[SPF_ST_TXEMPTY] = txFifo.empty;
            rdData_d[SPF_ST_OVERRUN] = overrun_q;
            rdData_d[SPF_ST_ORDDONE] = ordSeen_q;
        end else if (avsAddress == SPF_REG_ORDCNT) begin
            rdData_d = ordCount_q;
        end else begin
            rdData_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avsReadData <= '0;
        end else if (regRd) begin
            avsReadData <= rdData_d;
        end
    end

    // Sticky status: a new event wins over a write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_q <= 1'b0;
            ordSeen_q <= 1'b0;
        end else begin
            if (beatDone && rxFifo.full) begin
                overrun_q <= 1'b1;
            end else if (regWr && avsAddress == SPF_REG_STATUS
                         && avsWriteData[SPF_ST_OVERRUN]) begin
                overrun_q <= 1'b0;
            end
            if (ordNow) begin
                ordSeen_q <= 1'b1;
            end else if (regWr && avsAddress == SPF_REG_STATUS
                         && avsWriteData[SPF_ST_ORDDONE]) begin
                ordSeen_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ordCount_q <= '0;
        end else if (ordNow) begin
            ordCount_q <= ordCount_q + 1'b1;
        end
    end

    // Build the 16-bit receive word
    always_comb begin
        rxWord = '0;
        if (cfgEnc) begin
            rxWord[7:0] = pcsRxData[7:0];
            rxWord[SPF_W_CTRL] = pcsRxCtrl;
            rxWord[SPF_W_ERR] = pcsRxCodeErr;
        end else begin
            rxWord[9:0] = pcsRxData;
        end
        rxWord[SPF_W_SYNC] = pcsRxSync;
        rxWord[SPF_W_DISP] = pcsRxDispErr;
        rxWord[SPF_W_PATT] = pcsRxPattern;
        rxWord[SPF_W_RD] = pcsRxRunDisp;
        if (byteRevActive) begin
            rxWordOrd = {rxWord[7:0], rxWord[15:8]};
        end else begin
            rxWordOrd = rxWord;
        end
    end

    // Manual byte ordering: armed while request is low
    assign ordNow = pcsRxValid && cfgManual && rxByteOrderReq && ordArmed_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ordArmed_q <= 1'b1;
        end else if (ordNow) begin
            ordArmed_q <= 1'b0;
        end else if (!rxByteOrderReq) begin
            ordArmed_q <= 1'b1;
        end
    end

    assign rxByteOrderDone = ordNow;

    // Word placement into beat slots
    assign idxUse = ordNow ? 2'b00 : idx_q;
    assign beatDone = pcsRxValid && (idxUse == spfLastIdx(cfgDouble, cfgDeser));

    always_comb begin
        beat_d = ordNow ? '0 : beat_q;
        beat_d[spfSlotOf(idxUse, cfgDouble, cfgDeser) * SPF_SLOT_W +: SPF_SLOT_W]
            = rxWordOrd;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            beat_q <= '0;
            idx_q <= '0;
        end else if (pcsRxValid) begin
            if (beatDone) begin
                beat_q <= '0;
                idx_q <= '0;
            end else begin
                beat_q <= beat_d;
                idx_q <= idxUse + 1'b1;
            end
        end
    end

    // Receive parallel clock: one pulse per recovered word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxStdClkOut <= 1'b0;
        end else begin
            rxStdClkOut <= pcsRxValid;
        end
    end

    assign rxFifo.push = beatDone;
    assign rxFifo.pushData = beat_d;
    assign rxFifo.pop = rxCoreClkEn;

    spf_fifo #(.W(SPF_BUS_W), .DEPTH(DEPTH)) uRxFifo (
        .clk(clk),
        .rst_n(rst_n),
        .port(rxFifo.store)
    );

    assign rxParallelData = rxFifo.popData;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxPopPend_q <= 1'b0;
        end else begin
            rxPopPend_q <= rxCoreClkEn && !rxFifo.empty;
        end
    end

    assign rxDataValid = rxPopPend_q;

    // Flags sampled on the core clock strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxPcFifoFull <= 1'b0;
            rxPcFifoEmpty <= 1'b1;
        end else if (rxCoreClkEn) begin
            rxPcFifoFull <= rxFifo.full;
            rxPcFifoEmpty <= rxFifo.empty;
        end
    end

    // Transmit parallel clock divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (div_q == DW'(TX_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign txTick = (div_q == DW'(TX_DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txStdClkOut <= 1'b0;
        end else begin
            txStdClkOut <= txTick;
        end
    end

    assign txFifo.push = txCoreClkEn && txWrite;
    assign txFifo.pushData = txParallelData;
    assign txFifo.pop = txTick;

    spf_fifo #(.W(SPF_BUS_W), .DEPTH(DEPTH)) uTxFifo (
        .clk(clk),
        .rst_n(rst_n),
        .port(txFifo.store)
    );

    assign txPcsData = txFifo.popData;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txPopPend_q <= 1'b0;
        end else begin
            txPopPend_q <= txTick && !txFifo.empty;
        end
    end

    assign txPcsValid = txPopPend_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txPcFifoFull <= 1'b0;
            txPcFifoEmpty <= 1'b1;
        end else if (txCoreClkEn) begin
            txPcFifoFull <= txFifo.full;
            txPcFifoEmpty <= txFifo.empty;
        end
    end
endmodule : spf_rx_port
`default_nettype wire

// ---- spf_pkg.sv ----
// Constants and helpers for the standard PCS fabric receive port
package spf_pkg;
    localparam int SPF_SLOT_W = 16;
    localparam int SPF_SLOTS = 4;
    localparam int SPF_BUS_W = SPF_SLOT_W * SPF_SLOTS;
    localparam int SPF_FIFO_DEPTH = 8;
    localparam int SPF_TX_DIV = 4;
    // Register byte addresses
    localparam logic [7:0] SPF_REG_CTRL = 8'h00;
    localparam logic [7:0] SPF_REG_STATUS = 8'h04;
    localparam logic [7:0] SPF_REG_ORDCNT = 8'h08;
    // Control field positions and reset value
    localparam int SPF_CTRL_DOUBLE = 0;
    localparam int SPF_CTRL_DESER = 1;
    localparam int SPF_CTRL_MANUAL = 2;
    localparam int SPF_CTRL_BYTEREV = 3;
    localparam int SPF_CTRL_ENC = 4;
    localparam int SPF_CTRL_PMA_LO = 5;
    localparam int SPF_CTRL_W = 7;
    localparam logic [SPF_CTRL_W-1:0] SPF_CTRL_RESET = 7'h00;
    // Status field positions
    localparam int SPF_ST_RXFULL = 0;
    localparam int SPF_ST_RXEMPTY = 1;
    localparam int SPF_ST_TXFULL = 2;
    localparam int SPF_ST_TXEMPTY = 3;
    localparam int SPF_ST_OVERRUN = 4;
    localparam int SPF_ST_ORDDONE = 5;
    // Word field positions
    localparam int SPF_W_CTRL = 8;
    localparam int SPF_W_ERR = 9;
    localparam int SPF_W_SYNC = 10;
    localparam int SPF_W_DISP = 11;
    localparam int SPF_W_PATT = 12;
    localparam int SPF_W_RD = 15;

    typedef enum logic [1:0] {
        SPF_PMA_8,
        SPF_PMA_10,
        SPF_PMA_16,
        SPF_PMA_20
    } spf_pma_t;

    // Slot taken by the n-th word of a beat
    function automatic logic [1:0] spfSlotOf(input logic [1:0] idx, input logic dbl,
                                             input logic deser);
        if (!dbl && deser) begin
            spfSlotOf = {idx[0], 1'b0};
        end else begin
            spfSlotOf = idx;
        end
    endfunction : spfSlotOf

    // Index of the last word in a beat
    function automatic logic [1:0] spfLastIdx(input logic dbl, input logic deser);
        spfLastIdx = {dbl & deser, dbl | deser};
    endfunction : spfLastIdx
endpackage : spf_pkg

// ---- spf_fifo_if.sv ----
// Push and pop signals of one phase compensation FIFO
`timescale 1ns/1ns
`default_nettype none
interface spf_fifo_if #(parameter int W = 64);
    logic push;
    logic [W-1:0] pushData;
    logic pop;
    logic [W-1:0] popData;
    logic full;
    logic empty;
    modport store (input push, input pushData, input pop, output popData, output full,
                   output empty);
    modport user (output push, output pushData, output pop, input popData, input full,
                  input empty);
endinterface : spf_fifo_if
`default_nettype wire

// ---- spf_fifo.sv ----
// Phase compensation FIFO storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module spf_fifo #(
    parameter int W = 64,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Push and pop
    spf_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gCheck
            $error("spf_fifo depth must be a power of two of at least two");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic doPush;
    logic doPop;

    assign port.full = (count_q == (AW + 1)'(DEPTH));
    assign port.empty = (count_q == '0);
    assign doPush = port.push && !port.full;
    assign doPop = port.pop && !port.empty;

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_q] <= port.pushData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port.popData <= '0;
            rdPtr_q <= '0;
        end else if (doPop) begin
            port.popData <= mem[rdPtr_q];
            rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
        end else if (doPush) begin
            wrPtr_q <= wrPtr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (doPush && !doPop) begin
            count_q <= count_q + 1'b1;
        end else if (doPop && !doPush) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule : spf_fifo
`default_nettype wire

// ---- spf_rx_properties.sv ----
// Concurrent checks on the fabric receive port
`timescale 1ns/1ns
`default_nettype none
module spf_rx_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic pcsRxValid,
    input wire logic rxCoreClkEn,
    input wire logic rxDataValid,
    input wire logic rxStdClkOut,
    input wire logic rxPcFifoFull,
    input wire logic rxPcFifoEmpty,
    input wire logic rxByteOrderReq,
    input wire logic rxByteOrderDone,
    input wire logic txCoreClkEn,
    input wire logic txStdClkOut,
    input wire logic txPcFifoFull,
    input wire logic txPcFifoEmpty,
    input wire logic txPcsValid
);
    logic held_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Set once an ordering ran, cleared when the request drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= 1'b0;
        end else if (!rxByteOrderReq) begin
            held_q <= 1'b0;
        end else if (rxByteOrderDone) begin
            held_q <= 1'b1;
        end
    end
    sequence reqStart;
        $rose(avsRead | avsWrite);
    endsequence
    sequence oneWait;
        avsWaitRequest ##1 !avsWaitRequest;
    endsequence
    chk_bus_one_wait: assert property (reqStart |-> oneWait)
        else $error("bus request did not see exactly one wait state");
    chk_done_cause: assert property (rxByteOrderDone |-> pcsRxValid && rxByteOrderReq)
        else $error("ordering done without request and word");
    chk_done_rearm: assert property (rxByteOrderDone |-> !held_q)
        else $error("second ordering without request drop");
    chk_rxclk_follow: assert property (1'b1 |=> rxStdClkOut == $past(pcsRxValid))
        else $error("receive parallel clock not following recovered words");
    chk_pop_cause: assert property (rxDataValid |-> $past(rxCoreClkEn))
        else $error("receive beat without core clock tick");
    chk_rx_flags_sync: assert property (!rxCoreClkEn |=> $stable({rxPcFifoFull, rxPcFifoEmpty}))
        else $error("receive flags moved off a core clock tick");
    chk_tx_flags_sync: assert property (!txCoreClkEn |=> $stable({txPcFifoFull, txPcFifoEmpty}))
        else $error("transmit flags moved off a core clock tick");
    chk_flags_excl: assert property (!(rxPcFifoFull && rxPcFifoEmpty) && !(txPcFifoFull && txPcFifoEmpty))
        else $error("full and empty together");
    chk_tx_beat_tick: assert property (txPcsValid |-> txStdClkOut)
        else $error("transmit beat off the parallel clock");
endmodule : spf_rx_properties
`default_nettype wire

// ---- spf_fabric_model.sv ----
// Fabric logic that issues byte ordering requests
`timescale 1ns/1ns
`default_nettype none
module spf_fabric_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench command
    input wire logic ordGo,
    // Port side
    input wire logic pcsRxValid,
    input wire logic rxByteOrderDone,
    output logic rxByteOrderReq
);
    logic go_q;
    // Same clock as the port, so done needs no synchronizer stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            go_q <= 1'b0;
            rxByteOrderReq <= 1'b0;
        end else begin
            go_q <= ordGo;
            if (ordGo && !go_q) begin
                rxByteOrderReq <= 1'b1;
            end else if (rxByteOrderDone && pcsRxValid) begin
                rxByteOrderReq <= 1'b0;
            end
        end
    end
endmodule : spf_fabric_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the fabric receive port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spf_pkg::*;
    localparam int DEPTH = 4;
    localparam int TX_DIV = 32;
    logic clk, rst_n, avsRead, avsWrite, avsWaitRequest, pcsRxValid, pcsRxCtrl, pcsRxCodeErr;
    logic pcsRxSync, pcsRxDispErr, pcsRxPattern, pcsRxRunDisp, rxCoreClkEn, rxDataValid;
    logic rxStdClkOut, rxPcFifoFull, rxPcFifoEmpty, rxByteOrderReq, rxByteOrderDone, ordGo;
    logic txCoreClkEn, txWrite, txStdClkOut, txPcFifoFull, txPcFifoEmpty, txPcsValid, doneSeen;
    logic [7:0] avsAddress;
    logic [3:0] avsByteEnable;
    logic [9:0] pcsRxData;
    logic [31:0] avsWriteData, avsReadData, rd;
    logic [63:0] rxParallelData, txParallelData, txPcsData, exp;
    int fails, comparisons, cnt;
    spf_rx_port #(.DEPTH(DEPTH), .TX_DIV(TX_DIV)) u_dut (.clk, .rst_n, .avsAddress, .avsRead,
        .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .pcsRxValid,
        .pcsRxData, .pcsRxCtrl, .pcsRxCodeErr, .pcsRxSync, .pcsRxDispErr, .pcsRxPattern,
        .pcsRxRunDisp, .rxCoreClkEn, .rxParallelData, .rxDataValid, .rxStdClkOut, .rxPcFifoFull,
        .rxPcFifoEmpty, .rxByteOrderReq, .rxByteOrderDone, .txCoreClkEn, .txWrite,
        .txParallelData, .txStdClkOut, .txPcFifoFull, .txPcFifoEmpty, .txPcsData, .txPcsValid);
    spf_fabric_model u_fab (.clk, .rst_n, .ordGo, .pcsRxValid, .rxByteOrderDone, .rxByteOrderReq);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic waitHigh(ref logic sig);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sig !== 1'b1 && n < 100);
        if (sig !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask : waitHigh
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsRead <= !wr;
        avsWrite <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 100);
        if (avsWaitRequest !== 1'b0) begin
            fails++;
            close_out();
        end
        rd = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : bus
    task automatic regChk(input logic [7:0] a, input logic [31:0] want);
        bus(1'b0, a, 32'h0);
        check(64'(rd), 64'(want));
    endtask : regChk
    task automatic word(input logic [9:0] d);
        @(posedge clk);
        pcsRxValid <= 1'b1;
        pcsRxData <= d;
        @(posedge clk);
        doneSeen = rxByteOrderDone;
        pcsRxValid <= 1'b0;
    endtask : word
    task automatic pop(input logic [63:0] want);
        @(posedge clk);
        rxCoreClkEn <= 1'b1;
        @(posedge clk);
        rxCoreClkEn <= 1'b0;
        @(posedge clk);
        check(64'(rxDataValid), 64'h1);
        check(rxParallelData, want);
    endtask : pop
    task automatic idleChk();
        @(posedge clk);
        {rxCoreClkEn, txCoreClkEn} <= 2'b11;
        @(posedge clk);
        {rxCoreClkEn, txCoreClkEn} <= 2'b00;
        @(posedge clk);
        check(64'({rxPcFifoFull, rxPcFifoEmpty, txPcFifoFull, txPcFifoEmpty}), 64'h5);
    endtask : idleChk
    initial begin
        rst_n = 1'b0;
        {avsRead, avsWrite, pcsRxValid, rxCoreClkEn, txCoreClkEn, txWrite, ordGo} = '0;
        {pcsRxCtrl, pcsRxCodeErr, pcsRxSync, pcsRxDispErr, pcsRxPattern, pcsRxRunDisp} = '0;
        {avsAddress, avsWriteData, pcsRxData, txParallelData} = '0;
        avsByteEnable = 4'hf;
        repeat (20) @(posedge clk);
        check(64'({rxPcFifoFull, rxPcFifoEmpty, txPcFifoFull, txPcFifoEmpty}), 64'h5);
        rst_n <= 1'b1;
        regChk(SPF_REG_CTRL, 32'h0);
        bus(1'b1, 8'h0c, 32'h7f);
        regChk(8'h0c, 32'h0);
        regChk(SPF_REG_CTRL, 32'h0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, SPF_REG_CTRL, 32'(m));
            cnt = (m == 3) ? 4 : (m == 0) ? 1 : 2;
            exp = '0;
            for (int k = 0; k < cnt; k++) begin
                word(10'(16 * m + k + 1));
                exp[((m == 2) ? 2 * k : k) * 16 +: 16] = 16'(16 * m + k + 1);
            end
            pop(exp);
        end
        {pcsRxCtrl, pcsRxCodeErr, pcsRxSync, pcsRxDispErr, pcsRxPattern, pcsRxRunDisp} <= 6'h35;
        bus(1'b1, SPF_REG_CTRL, 32'h58);
        word(10'h0a5);
        pop(64'ha58b);
        bus(1'b1, SPF_REG_CTRL, 32'h18);
        word(10'h0a5);
        pop(64'h8ba5);
        {pcsRxCtrl, pcsRxCodeErr, pcsRxSync, pcsRxDispErr, pcsRxPattern, pcsRxRunDisp} <= '0;
        bus(1'b1, SPF_REG_CTRL, 32'h05);
        word(10'h011);
        check(64'(doneSeen), 64'h0);
        ordGo <= 1'b1;
        waitHigh(rxByteOrderReq);
        word(10'h022);
        check(64'(doneSeen), 64'h1);
        ordGo <= 1'b0;
        word(10'h033);
        pop(64'h00330022);
        regChk(SPF_REG_ORDCNT, 32'h1);
        regChk(SPF_REG_STATUS, 32'h2a);
        bus(1'b1, SPF_REG_CTRL, 32'h0);
        for (int i = 0; i <= DEPTH; i++) begin
            word(10'(i + 1));
        end
        regChk(SPF_REG_STATUS, 32'h39);
        for (int i = 0; i < DEPTH; i++) begin
            pop(64'(i + 1));
            if (i == 0) check(64'(rxPcFifoFull), 64'h1);
        end
        idleChk();
        bus(1'b1, SPF_REG_STATUS, 32'h30);
        regChk(SPF_REG_STATUS, 32'h0a);
        waitHigh(txStdClkOut);
        for (int i = 0; i <= DEPTH; i++) begin
            @(posedge clk);
            {txCoreClkEn, txWrite} <= 2'b11;
            txParallelData <= 64'h1000 + 64'(i);
        end
        @(posedge clk);
        {txCoreClkEn, txWrite} <= 2'b00;
        @(posedge clk);
        check(64'({txPcFifoFull, txPcFifoEmpty}), 64'h2);
        regChk(SPF_REG_STATUS, 32'h06);
        for (int i = 0; i < DEPTH; i++) begin
            waitHigh(txPcsValid);
            check(txPcsData, 64'h1000 + 64'(i));
        end
        idleChk();
        close_out();
    end
endmodule : tb_top
bind spf_rx_port spf_rx_properties u_props (.clk, .rst_n, .avsRead, .avsWrite, .avsWaitRequest,
    .pcsRxValid, .rxCoreClkEn, .rxDataValid, .rxStdClkOut, .rxPcFifoFull, .rxPcFifoEmpty,
    .rxByteOrderReq, .rxByteOrderDone, .txCoreClkEn, .txStdClkOut, .txPcFifoFull,
    .txPcFifoEmpty, .txPcsValid);
`default_nettype wire
